/* rtl/l2a_device.sv */
// Register access over APB and the address map were left to the implementer.
`timescale 1ns/1ns
`default_nettype none

module l2a_device
	import l2a_pkg::*;
#(
	parameter bit HAS_CHECK_RAM = 1'b1,
	parameter int NUM_WAYS = 8
) (
	input wire logic pclk,
	input wire logic presetn,
	l2a_link_if.device link,
	input wire logic ram_start,
	output logic ram_busy,
	output logic tag_done,
	output logic data_done,
	output logic ram_mux_two,
	output logic ecc_select,
	output logic fwd_disable,
	output logic wc_disable,
	output logic wa_delay_disable,
	output logic wa_combine_disable,
	output logic wa_disable,
	output logic check_enable,
	output logic inner_attr_select,
	output logic [3:0] tag_lat_cycles,
	output logic [3:0] data_lat_cycles,
	input wire logic alloc_req,
	output logic alloc_valid,
	output logic alloc_none,
	output logic [NUM_WAYS-1:0] alloc_way,
	output logic [NUM_WAYS-1:0] locked_ways
);

	localparam int PTR_W = (NUM_WAYS > 1) ? $clog2(NUM_WAYS) : 1;

	logic [31:0] aux_r;
	logic [NUM_WAYS-1:0] lock_r;
	logic ack_r;
	logic undef_r;
	logic [31:0] rdata_r;
	logic hit_aux;
	logic hit_lock;
	logic take;
	logic refuse;
	logic [31:0] aux_wmask;
	logic [3:0] tag_cnt_r;
	logic [3:0] data_cnt_r;
	logic mux_two_r;
	logic [PTR_W-1:0] rr_ptr_r;
	logic [PTR_W-1:0] pick;
	logic pick_ok;
	logic alloc_valid_r;
	logic alloc_none_r;
	logic [NUM_WAYS-1:0] alloc_way_r;

	assign hit_aux = link.opc1 == `L2A_OPC1 && link.crn == `L2A_CRN
		&& link.coproc_minor_field == `L2A_CRM && link.opc2 == `L2A_OPC2_AUX;
	assign hit_lock = link.opc1 == `L2A_OPC1 && link.crn == `L2A_CRN
		&& link.coproc_minor_field == `L2A_CRM && link.opc2 == `L2A_OPC2_LOCK;

	// The cycle that acknowledges a transfer still sees req high; skip it
	assign take = link.req && !ack_r;

	// Unknown encodings are refused as well, like any unimplemented register
	assign refuse = !link.priv
		|| !(hit_aux || hit_lock)
		|| (hit_aux && link.wr && !link.secure);

	// Check enable is not storable when the check RAM is absent
	assign aux_wmask = HAS_CHECK_RAM ? `L2A_AUX_WMASK
		: (`L2A_AUX_WMASK & ~(32'h1 << `L2A_CHECK_EN_BIT));

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ack_r <= 1'b0;
			undef_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else begin
			ack_r <= take;
			if (take) begin
				undef_r <= refuse;
				if (refuse || link.wr) begin
					rdata_r <= 32'h0000_0000;
				end else if (hit_aux) begin
					rdata_r <= aux_r;
				end else begin
					rdata_r <= {{(32 - NUM_WAYS){1'b0}}, lock_r};
				end
			end
		end
	end

	assign link.ack = ack_r;
	assign link.undef = undef_r;
	assign link.rdata = rdata_r;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			aux_r <= `L2A_AUX_RESET;
		end else if (take && !refuse && link.wr && hit_aux) begin
			aux_r <= link.wdata & aux_wmask;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lock_r <= NUM_WAYS'(`L2A_LOCK_RESET);
		end else if (take && !refuse && link.wr && hit_lock) begin
			lock_r <= link.wdata[NUM_WAYS-1:0];
		end
	end

	assign ram_mux_two = !aux_r[`L2A_MUX_ONE_BIT];
	assign ecc_select = aux_r[`L2A_ECC_SEL_BIT];
	assign fwd_disable = aux_r[`L2A_FWD_DIS_BIT];
	assign wc_disable = aux_r[`L2A_WC_DIS_BIT];
	assign wa_delay_disable = aux_r[`L2A_WA_DELAY_DIS_BIT];
	assign wa_combine_disable = aux_r[`L2A_WA_COMB_DIS_BIT];
	assign wa_disable = aux_r[`L2A_WA_DIS_BIT];
	assign check_enable = aux_r[`L2A_CHECK_EN_BIT];
	assign inner_attr_select = aux_r[`L2A_INNER_SEL_BIT];
	assign tag_lat_cycles =
		l2a_tag_cycles(aux_r[`L2A_TAG_LAT_HI:`L2A_TAG_LAT_LO]);
	assign data_lat_cycles =
		l2a_data_cycles(aux_r[`L2A_DATA_LAT_HI:`L2A_DATA_LAT_LO]);
	assign locked_ways = lock_r;

	// RAM access timer: figures are sampled when an access starts, so a
	// register write during an access only affects the next one
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tag_cnt_r <= 4'h0;
			data_cnt_r <= 4'h0;
			mux_two_r <= 1'b1;
		end else if (ram_start && !ram_busy) begin
			tag_cnt_r <= tag_lat_cycles;
			data_cnt_r <= data_lat_cycles;
			mux_two_r <= ram_mux_two;
		end else begin
			if (tag_cnt_r != 4'h0) begin
				tag_cnt_r <= tag_cnt_r - 4'h1;
			end
			if (data_cnt_r != 4'h0) begin
				data_cnt_r <= data_cnt_r - 4'h1;
			end
		end
	end

	assign ram_busy = (tag_cnt_r != 4'h0) || (data_cnt_r != 4'h0);
	assign tag_done = tag_cnt_r == 4'h1;
	assign data_done = data_cnt_r == 4'h1;

	// Round robin from the pointer, skipping locked ways
	always_comb begin
		logic [PTR_W-1:0] idx;
		idx = '0;
		pick = '0;
		pick_ok = 1'b0;
		for (int k = NUM_WAYS - 1; k >= 0; k--) begin
			idx = PTR_W'((32'(rr_ptr_r) + k) % NUM_WAYS);
			if (!lock_r[idx]) begin
				pick = idx;
				pick_ok = 1'b1;
			end
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			rr_ptr_r <= '0;
			alloc_valid_r <= 1'b0;
			alloc_none_r <= 1'b0;
			alloc_way_r <= '0;
		end else begin
			alloc_valid_r <= alloc_req && pick_ok;
			alloc_none_r <= alloc_req && !pick_ok;
			if (alloc_req && pick_ok) begin
				alloc_way_r <= NUM_WAYS'(1) << pick;
				rr_ptr_r <= PTR_W'((32'(pick) + 1) % NUM_WAYS);
			end
		end
	end

	assign alloc_valid = alloc_valid_r;
	assign alloc_none = alloc_none_r;
	assign alloc_way = alloc_way_r;

endmodule

`default_nettype wire

/* rtl/l2a_host.sv */
`timescale 1ns/1ns
`default_nettype none

// Core-side transfer engine; the lock procedure
// is sequenced by software through these registers.
module l2a_host
	import l2a_pkg::*;
(
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	l2a_link_if.host link
);

	l2a_host_state_type state_r;
	logic [31:0] cmd_r;
	logic [31:0] wdata_r;
	logic [31:0] rdata_r;
	logic done_r;
	logic undef_r;
	logic wr_en;
	logic mapped;

	assign mapped = paddr == `L2A_HOST_CMD || paddr == `L2A_HOST_WDATA
		|| paddr == `L2A_HOST_RDATA || paddr == `L2A_HOST_STATUS;
	assign wr_en = psel && penable && pwrite && mapped;
	assign pready = 1'b1;
	assign pslverr = psel && penable && !mapped;

	always_comb begin
		prdata = 32'h0000_0000;
		if (paddr == `L2A_HOST_CMD) begin
			prdata = cmd_r;
		end else if (paddr == `L2A_HOST_WDATA) begin
			prdata = wdata_r;
		end else if (paddr == `L2A_HOST_RDATA) begin
			prdata = rdata_r;
		end else if (paddr == `L2A_HOST_STATUS) begin
			prdata[`L2A_STAT_BUSY_BIT] = state_r == L2A_HS_WAIT;
			prdata[`L2A_STAT_DONE_BIT] = done_r;
			prdata[`L2A_STAT_UNDEF_BIT] = undef_r;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			wdata_r <= 32'h0000_0000;
		end else if (wr_en && paddr == `L2A_HOST_WDATA && state_r == L2A_HS_IDLE) begin
			wdata_r <= pwdata;
		end
	end

	// Orders arriving while a transfer is open are dropped, so the link
	// fields never change under a pending request
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_r <= L2A_HS_IDLE;
			cmd_r <= 32'h0000_0000;
		end else begin
			unique case (state_r)
				L2A_HS_IDLE: begin
					if (wr_en && paddr == `L2A_HOST_CMD) begin
						cmd_r <= pwdata & 32'h0007_7ff7;
						state_r <= L2A_HS_WAIT;
					end
				end
				L2A_HS_WAIT: begin
					if (link.ack) begin
						state_r <= L2A_HS_IDLE;
					end
				end
			endcase
		end
	end

	// Completion wins over a clear in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			done_r <= 1'b0;
			undef_r <= 1'b0;
			rdata_r <= 32'h0000_0000;
		end else if (state_r == L2A_HS_WAIT && link.ack) begin
			done_r <= 1'b1;
			undef_r <= link.undef;
			rdata_r <= link.rdata;
		end else if (wr_en && paddr == `L2A_HOST_STATUS
			&& pwdata[`L2A_STAT_DONE_BIT]) begin
			done_r <= 1'b0;
		end
	end

	assign link.req = state_r == L2A_HS_WAIT;
	assign link.wr = cmd_r[`L2A_CMD_WR_BIT];
	assign link.opc1 = cmd_r[`L2A_CMD_OPC1_LO +: 3];
	assign link.crn = cmd_r[`L2A_CMD_CRN_LO +: 4];
	assign link.coproc_minor_field = cmd_r[`L2A_CMD_CRM_LO +: 4];
	assign link.opc2 = cmd_r[`L2A_CMD_OPC2_LO +: 3];
	assign link.priv = cmd_r[`L2A_CMD_PRIV_BIT];
	assign link.secure = cmd_r[`L2A_CMD_SECURE_BIT];
	assign link.wdata = wdata_r;

endmodule

`default_nettype wire

/* rtl/l2a_link_if.sv */
`timescale 1ns/1ns
`default_nettype none

interface l2a_link_if;
	logic req;
	logic wr;
	logic [2:0] opc1;
	logic [3:0] crn;
	logic [3:0] coproc_minor_field;
	logic [2:0] opc2;
	logic priv;
	logic secure;
	logic [31:0] wdata;
	logic ack;
	logic undef;
	logic [31:0] rdata;

	modport device (
		input req, wr, opc1, crn, coproc_minor_field, opc2, priv, secure, wdata,
		output ack, undef, rdata
	);

	modport host (
		output req, wr, opc1, crn, coproc_minor_field, opc2, priv, secure, wdata,
		input ack, undef, rdata
	);
endinterface

`default_nettype wire

/* rtl/l2a_pkg.sv */
`default_nettype none
`include "l2a_regs.svh"

package l2a_pkg;

	typedef enum {L2A_HS_IDLE, L2A_HS_WAIT} l2a_host_state_type;

	function automatic logic [3:0] l2a_tag_cycles(input logic [2:0] code);
		if (code <= 3'h1) begin
			return `L2A_TAG_LAT_MIN;
		end else if (code == 3'h2) begin
			return `L2A_TAG_LAT_MID;
		end
		return `L2A_TAG_LAT_MAX;
	endfunction

	function automatic logic [3:0] l2a_data_cycles(input logic [3:0] code);
		if (code <= 4'h1) begin
			return `L2A_DATA_LAT_MIN;
		end else if (code >= `L2A_DATA_LAT_SAT) begin
			return `L2A_DATA_LAT_MAX;
		end
		return code + 4'h1;
	endfunction

endpackage

`default_nettype wire

/* rtl/l2a_regs.svh */
`ifndef L2A_REGS_SVH
`define L2A_REGS_SVH

// Coprocessor transfer encoding of the two registers
`define L2A_OPC1 3'h1
`define L2A_CRN 4'h9
`define L2A_CRM 4'h0
`define L2A_OPC2_LOCK 3'h0
`define L2A_OPC2_AUX 3'h2

// Auxiliary configuration field positions
`define L2A_MUX_ONE_BIT 29
`define L2A_ECC_SEL_BIT 28
`define L2A_FWD_DIS_BIT 27
`define L2A_WC_DIS_BIT 25
`define L2A_WA_DELAY_DIS_BIT 24
`define L2A_WA_COMB_DIS_BIT 23
`define L2A_WA_DIS_BIT 22
`define L2A_CHECK_EN_BIT 21
`define L2A_INNER_SEL_BIT 16
`define L2A_TAG_LAT_HI 8
`define L2A_TAG_LAT_LO 6
`define L2A_DATA_LAT_HI 3
`define L2A_DATA_LAT_LO 0

// Writable bits; everything else is reserved and reads as zero
`define L2A_AUX_WMASK 32'h3be1_01cf
`define L2A_LOCK_WMASK 32'h0000_00ff

// Reset values
`define L2A_AUX_RESET 32'h0000_0000
`define L2A_LOCK_RESET 8'h00

// Latency counts in cycles
`define L2A_TAG_LAT_MIN 4'h2
`define L2A_TAG_LAT_MID 4'h3
`define L2A_TAG_LAT_MAX 4'h4
`define L2A_DATA_LAT_MIN 4'h2
`define L2A_DATA_LAT_MAX 4'hd
`define L2A_DATA_LAT_SAT 4'hc

// Host register offsets and fields
`define L2A_HOST_CMD 12'h000
`define L2A_HOST_WDATA 12'h004
`define L2A_HOST_RDATA 12'h008
`define L2A_HOST_STATUS 12'h00c
`define L2A_CMD_OPC2_LO 0
`define L2A_CMD_CRM_LO 4
`define L2A_CMD_CRN_LO 8
`define L2A_CMD_OPC1_LO 12
`define L2A_CMD_WR_BIT 16
`define L2A_CMD_PRIV_BIT 17
`define L2A_CMD_SECURE_BIT 18
`define L2A_STAT_BUSY_BIT 0
`define L2A_STAT_DONE_BIT 1
`define L2A_STAT_UNDEF_BIT 2

`endif

/* testbench/l2a_link_asserts.sv */
`timescale 1ns/1ns
`default_nettype none
`include "l2a_regs.svh"
module l2a_link_asserts (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic req,
	input wire logic wr,
	input wire logic [2:0] opc1,
	input wire logic [3:0] crn,
	input wire logic [3:0] coproc_minor_field,
	input wire logic [2:0] opc2,
	input wire logic priv,
	input wire logic secure,
	input wire logic ack,
	input wire logic undef,
	input wire logic [31:0] rdata
);
	logic take, base_ok, aux_sel, lock_sel;
	assign take = req && !ack;
	assign base_ok = opc1 == `L2A_OPC1 && crn == `L2A_CRN && coproc_minor_field == `L2A_CRM;
	assign aux_sel = base_ok && opc2 == `L2A_OPC2_AUX;
	assign lock_sel = base_ok && opc2 == `L2A_OPC2_LOCK;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	property p_ack_next; take |=> ack; endproperty
	a_ack_next: assert property (p_ack_next) else $error("ack late");
	property p_ack_pulse; ack |=> !ack; endproperty
	a_ack_pulse: assert property (p_ack_pulse) else $error("ack held");
	property p_user_undef; take && !priv |=> undef; endproperty
	a_user_undef: assert property (p_user_undef) else $error("user access taken");
	property p_ns_write; take && wr && !secure && aux_sel |=> undef; endproperty
	a_ns_write: assert property (p_ns_write) else $error("nonsecure write taken");
	property p_aux_read; take && priv && !wr && aux_sel |=> ack && !undef; endproperty
	a_aux_read: assert property (p_aux_read) else $error("read refused");
	property p_aux_write; take && priv && secure && aux_sel |=> !undef; endproperty
	a_aux_write: assert property (p_aux_write) else $error("write refused");
	property p_res_zero; ack && !wr && aux_sel |-> (rdata & ~`L2A_AUX_WMASK) == 32'h0; endproperty
	a_res_zero: assert property (p_res_zero) else $error("reserved bit set");
	property p_lock_read; ack && !wr && lock_sel && priv |-> rdata[31:8] == 24'h0 && !undef;
	endproperty
	a_lock_read: assert property (p_lock_read) else $error("lock read bad");
	property p_wr_zero; ack && wr |-> rdata == 32'h0; endproperty
	a_wr_zero: assert property (p_wr_zero) else $error("write data echoed");
endmodule
`default_nettype wire

/* testbench/tb.sv */
`timescale 1ns/1ns
`default_nettype none
`include "l2a_regs.svh"
module tb;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, aux_m, r, d;
	logic ram_start, ram_busy, tag_done, data_done, alloc_req, alloc_valid, alloc_none, u, e;
	logic ram_mux_two, ecc_select, fwd_disable, wc_disable, wa_delay_disable;
	logic wa_combine_disable, wa_disable, check_enable, inner_attr_select;
	logic [3:0] tag_lat_cycles, data_lat_cycles;
	logic [7:0] alloc_way, locked_ways, lock_m, w, seen;
	int fails, tests_run, cyc, seed, t, dd, tc, dc;
	l2a_link_if lk ();
	l2a_host l2a_host_i (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
		.pready, .pslverr, .link(lk));
	l2a_device l2a_device_i (.pclk, .presetn, .link(lk), .ram_start, .ram_busy, .tag_done,
		.data_done, .ram_mux_two, .ecc_select, .fwd_disable, .wc_disable, .wa_delay_disable,
		.wa_combine_disable, .wa_disable, .check_enable, .inner_attr_select, .tag_lat_cycles,
		.data_lat_cycles, .alloc_req, .alloc_valid, .alloc_none, .alloc_way, .locked_ways);
	l2a_link_asserts l2a_link_asserts_i (.pclk, .presetn, .req(lk.req), .wr(lk.wr),
		.opc1(lk.opc1), .crn(lk.crn), .coproc_minor_field(lk.coproc_minor_field), .opc2(lk.opc2), .priv(lk.priv),
		.secure(lk.secure), .ack(lk.ack), .undef(lk.undef), .rdata(lk.rdata));
	initial begin
		pclk = 0;
		forever #4 pclk = ~pclk;
	end
	task summarize;
		if (fails == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 30000) begin
			fails++;
			summarize;
		end
	end
	task chk(input string n, input logic [31:0] x, input logic [31:0] g);
		tests_run++;
		if (g !== x) begin
			$display("ERROR %s expected %h seen %h", n, x, g);
			fails++;
		end
	endtask
	task apb(input logic wt, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd,
		output logic er);
		psel <= 1'b1;
		pwrite <= wt;
		paddr <= a;
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1'b1;
		@(posedge pclk);
		while (pready !== 1'b1) @(posedge pclk);
		rd = prdata;
		er = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	// One coprocessor transfer; done is cleared afterwards so the next poll starts fresh
	task cp(input logic wt, input logic [2:0] o2, input logic pv, input logic sc,
		input logic [31:0] wd, output logic [31:0] rd, output logic un);
		logic [31:0] s;
		logic x;
		apb(1'b1, `L2A_HOST_WDATA, wd, s, x);
		apb(1'b1, `L2A_HOST_CMD, {13'h0, sc, pv, wt, 1'b0, 3'h1, 4'h9, 4'h0, 1'b0, o2}, s, x);
		do apb(1'b0, `L2A_HOST_STATUS, 32'h0, s, x); while (s[1] !== 1'b1);
		un = s[2];
		apb(1'b0, `L2A_HOST_RDATA, 32'h0, rd, x);
		apb(1'b1, `L2A_HOST_STATUS, 32'h2, s, x);
	endtask
	task alloc;
		alloc_req <= 1'b1;
		@(posedge pclk);
		alloc_req <= 1'b0;
		@(negedge pclk);
		w = alloc_way;
		u = alloc_none;
		e = alloc_valid;
		@(posedge pclk);
	endtask
	initial begin
		{psel, penable, pwrite, paddr, pwdata, ram_start, alloc_req} = '0;
		{fails, tests_run, cyc} = '0;
		seed = 32'h5cbd;
		aux_m = 32'h0;
		presetn = 1'b0;
		repeat (5) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		cp(1'b0, 3'h2, 1'b1, 1'b0, 32'h0, r, u);
		chk("aux reset", 32'h0, r);
		cp(1'b0, 3'h0, 1'b1, 1'b1, 32'h0, r, u);
		chk("lock reset", 32'h0, r);
		for (int m = 0; m < 8; m++) begin
			d = $random(seed);
			cp(m[0], 3'h2, m[1], m[2], d, r, u);
			e = m[1] && (!m[0] || m[2]);
			chk("undef", !e, u);
			if (e && m[0]) aux_m = d & `L2A_AUX_WMASK;
			chk("access rdata", (e && !m[0]) ? aux_m : 32'h0, r);
		end
		cp(1'b0, 3'h1, 1'b1, 1'b1, 32'h0, r, u);
		chk("bad encoding", 1, u);
		apb(1'b0, 12'h010, 32'h0, r, e);
		chk("pslverr", 1, e);
		for (int c = 0; c < 16; c++) begin
			d = ($random(seed) & 32'hfffffe30) | {c[2:0], 6'h0} | c[3:0];
			cp(1'b1, 3'h2, 1'b1, 1'b1, d, r, u);
			aux_m = d & `L2A_AUX_WMASK;
			cp(1'b0, 3'h2, 1'b1, 1'b0, 32'h0, r, u);
			chk("aux readback", aux_m, r);
			chk("cfg a", {~aux_m[29], aux_m[28:27], aux_m[25]},
				{ram_mux_two, ecc_select, fwd_disable, wc_disable});
			chk("cfg b", aux_m[24:21], {wa_delay_disable, wa_combine_disable, wa_disable,
				check_enable});
			chk("inner select", aux_m[16], inner_attr_select);
			tc = c[2:0] < 2 ? 2 : (c[2:0] == 2 ? 3 : 4);
			dc = c < 2 ? 2 : (c > 11 ? 13 : c + 1);
			chk("tag count", tc, tag_lat_cycles);
			chk("data count", dc, data_lat_cycles);
			ram_start <= 1'b1;
			@(posedge pclk);
			ram_start <= 1'b0;
			{t, dd} = '0;
			for (int k = 0; k < 16; k++) begin
				@(negedge pclk);
				chk("ram busy", k < (tc > dc ? tc : dc), ram_busy);
				if (tag_done === 1'b1) t = k + 1;
				if (data_done === 1'b1) dd = k + 1;
				@(posedge pclk);
			end
			chk("tag time", tc, t);
			chk("data time", dc, dd);
		end
		// The bench touches no cacheable data, so masking and eviction hold
		for (int i = 0; i < 8; i++) begin
			lock_m = ~(8'h1 << i);
			cp(1'b1, 3'h0, 1'b1, i[0], {24'h0, lock_m}, r, u);
			chk("locked", lock_m, locked_ways);
			repeat (2) begin
				alloc;
				chk("fill way", {2'b10, 8'h1 << i}, {e, u, w});
			end
			cp(1'b1, 3'h0, 1'b1, 1'b1, {24'h0, 8'h1 << i}, r, u);
			chk("relock", 8'h1 << i, locked_ways);
			alloc;
			chk("skip locked", 3'b100, {e, u, |(w & (8'h1 << i))});
		end
		cp(1'b1, 3'h0, 1'b1, 1'b1, 32'hff, r, u);
		alloc;
		chk("none", 2'b01, {e, u});
		cp(1'b1, 3'h0, 1'b1, 1'b0, 32'h0, r, u);
		seen = 8'h0;
		repeat (8) begin
			alloc;
			seen = seen | w;
		end
		chk("all ways", 8'hff, seen);
		summarize;
	end
endmodule
`default_nettype wire
